// file: vrc_bench.sv
// Self-checking bench for the voltage reference control register block.
`timescale 1ns/10ps
module voltage_reference_control_bench;
  import vrc_pkg::*;
  logic        clk_in;
  logic        reset_n_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        dir;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        pwr;
  logic        oe;
  logic        rng;
  logic        src;
  vrc_level_t  lvl;
  logic        conn;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          cmp_count = 0;
  vrc_ctrl DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .port_f_direction_in(dir), .ref_power_enable_out(pwr), .ref_pin_output_enable_out(oe),
    .ref_range_select_out(rng), .ref_source_select_out(src), .ref_level_value_out(lvl),
    .analog_out_pin_connect_out(conn));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n, 1, "access phase length");
  endtask
  task automatic outs(input logic [7:0] exp);
    repeat (3) @(posedge clk_in);
    check({24'h0, pwr, oe, rng, src, lvl}, {24'h0, exp}, "ladder outputs");
  endtask
  task automatic wr_rd(input logic [7:0] v);
    apb(1'b1, 12'h000, {24'h0, v}, 4'hf);
    apb(1'b0, 12'h000, 32'h0, 4'hf);
    check(rd, {24'h0, v}, "readback");
    check(err, 1'b0, "slave error on mapped read");
    outs(v);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    outs(8'h00);
    apb(1'b0, 12'h000, 32'h0, 4'hf);
    check(rd, 32'h0, "value after reset");
  endtask
  task automatic test_all_levels();
    for (int i = 0; i < 16; i++) begin
      wr_rd({i[3:0], 4'hf - i[3:0]});
    end
  endtask
  task automatic test_refused();
    wr_rd(8'h3c);
    apb(1'b1, 12'h000, 32'hc3, 4'he);
    apb(1'b1, 12'h004, 32'hff, 4'hf);
    check(err, 1'b0, "status write error");
    apb(1'b1, 12'h008, 32'hff, 4'hf);
    check(err, 1'b1, "unmapped write error");
    apb(1'b0, 12'h008, 32'h0, 4'hf);
    check(err, 1'b1, "unmapped read error");
    apb(1'b0, 12'h000, 32'h0, 4'hf);
    check(rd, 32'h3c, "value kept after refused writes");
  endtask
  task automatic test_pin();
    wr_rd(8'h40);
    dir <= 1'b0;
    repeat (10) @(posedge clk_in);
    check(conn, 1'b0, "pin connect with output direction");
    apb(1'b0, 12'h004, 32'h0, 4'hf);
    check(rd, 32'h0, "status with output direction");
    dir <= 1'b1;
    repeat (10) @(posedge clk_in);
    check(conn, 1'b1, "pin connect with input direction");
    apb(1'b0, 12'h004, 32'h0, 4'hf);
    check(rd, 32'h3, "status with pin connected");
    wr_rd(8'hbf);
    repeat (10) @(posedge clk_in);
    check(conn, 1'b0, "pin connect with output disabled");
    apb(1'b0, 12'h004, 32'h0, 4'hf);
    check(rd, 32'h1, "status with output disabled");
  endtask
  task automatic test_hold_reset();
    wr_rd(8'hff);
    repeat (50) @(posedge clk_in);
    check({pwr, oe, rng, src, lvl}, 8'hff, "value held while idle");
    wr_rd(8'h7f);
    repeat (50) @(posedge clk_in);
    check({pwr, oe, rng, src, lvl}, 8'h7f, "power off kept while idle");
    reset_n_in <= 1'b0;
    @(posedge clk_in);
    check({conn, pwr, oe, rng, src, lvl}, 9'h0, "outputs during reset");
    reset_n_in <= 1'b1;
    test_reset();
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // The whole sequence needs well under 2000 cycles.
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {reset_n_in, psel, penable, pwrite, paddr, pwdata, pstrb, dir} = '0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    test_reset();
    test_all_levels();
    test_refused();
    test_pin();
    test_hold_reset();
    wrap_up();
  end
endmodule

// file: vrc_ctrl.sv
// Voltage reference control register with APB slave and output gating.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "vrc_defs.svh"

// Functional notes
// - Reset clears reference power enable bit 7.
// - Reset clears pin output enable bit 6.
// - Reset clears range select bit 5.
// - Reset clears level value bits 3:0.
// - Register keeps contents across Sleep wake-up.
// - Pin output needs enable and direction bit.
// - Comparator settings never touch the reference.
// - Level value selects one of 16 taps.
// - Range bit picks level/24 or 1/4+level/32.
// - Source bit chooses supply rails or pins.
module vrc_ctrl #(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  // APB slave
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [ADDR_WIDTH-1:0]  paddr_in,
  input  wire logic [31:0]            pwdata_in,
  input  wire logic [3:0]             pstrb_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // Pin direction from the port logic, asynchronous to this block
  input  wire logic                   port_f_direction_in,
  // Analog ladder controls
  output logic                        ref_power_enable_out,
  output logic                        ref_pin_output_enable_out,
  output logic                        ref_range_select_out,
  output logic                        ref_source_select_out,
  output vrc_pkg::vrc_level_t         ref_level_value_out,
  output logic                        analog_out_pin_connect_out
);
  import vrc_pkg::*;

  // The decode compares against 12-bit offsets, so narrower buses cannot be served.
  if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : g_bad_addr_width
    $error("ADDR_WIDTH must be between 12 and 32");
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic is_ctrl(input logic [ADDR_WIDTH-1:0] a);
    is_ctrl = (a == ADDR_WIDTH'(`VRC_CTRL_ADDR));
  endfunction

  function automatic logic is_status(input logic [ADDR_WIDTH-1:0] a);
    is_status = (a == ADDR_WIDTH'(`VRC_STATUS_ADDR));
  endfunction

  // ---------------------------------------------------------------
  // Pin direction synchroniser
  // ---------------------------------------------------------------
  // The direction bit lives in another block's timing, so it is filtered
  // before it may connect the ladder to the pin.
  logic [`VRC_SYNC_STAGES-1:0] dir_sync;
  logic                        dir_stable;
  logic [`VRC_SYNC_STAGES-1:0] next_dir_sync;
  logic                        next_dir_stable;

  always_comb begin
    next_dir_sync   = {dir_sync[`VRC_SYNC_STAGES-2:0], port_f_direction_in};
    next_dir_stable = dir_stable;
    if (dir_sync[1] == dir_sync[2]) begin
      next_dir_stable = dir_sync[2];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir_sync   <= '0;
      dir_stable <= 1'b0;
    end else begin
      dir_sync   <= next_dir_sync;
      dir_stable <= next_dir_stable;
    end
  end

  // ---------------------------------------------------------------
  // APB slave and control register
  // ---------------------------------------------------------------
  // No wait state: setup is seen in IDLE, pready is raised the next cycle.
  vrc_state_e state;
  vrc_reg_t   ctrl;
  vrc_state_e next_state;
  vrc_reg_t   next_ctrl;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        access_done;

  assign access_done = (state == VRC_ACCESS) && psel_in && penable_in;

  always_comb begin
    next_state   = state;
    next_ctrl    = ctrl;
    next_prdata  = 32'h0000_0000;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (state)
      VRC_IDLE: begin
        if (psel_in && !penable_in) begin
          next_state  = VRC_ACCESS;
          next_pready = 1'b1;
          if (!pwrite_in) begin
            if (is_ctrl(paddr_in)) begin
              next_prdata = {24'h00_0000, ctrl};
            end else if (is_status(paddr_in)) begin
              next_prdata = {30'h0000_0000, analog_out_pin_connect_out, dir_stable};
            end else begin
              next_pslverr = 1'b1;
            end
          end else if (!is_ctrl(paddr_in) && !is_status(paddr_in)) begin
            next_pslverr = 1'b1;
          end
        end
      end
      VRC_ACCESS: begin
        next_state = VRC_IDLE;
        if (access_done && pwrite_in && is_ctrl(paddr_in) && pstrb_in[0]) begin
          next_ctrl = pwdata_in[7:0];
        end
      end
      default: begin
        next_state = VRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state       <= VRC_IDLE;
      ctrl        <= `VRC_CTRL_RESET;
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      state       <= next_state;
      ctrl        <= next_ctrl;
      prdata_out  <= next_prdata;
      pready_out  <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------
  // Ladder control outputs
  // ---------------------------------------------------------------
  // Outputs are registered copies of the register fields (pin connect also gated by
  // dir_stable), so each lags the register by one cycle.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_power_enable_out       <= 1'b0;
      ref_pin_output_enable_out  <= 1'b0;
      ref_range_select_out       <= 1'b0;
      ref_source_select_out      <= 1'b0;
      ref_level_value_out        <= 4'h0;
      analog_out_pin_connect_out <= 1'b0;
    end else begin
      ref_power_enable_out       <= ctrl[`VRC_BIT_POWER];
      ref_pin_output_enable_out  <= ctrl[`VRC_BIT_PIN_OE];
      ref_range_select_out       <= ctrl[`VRC_BIT_RANGE];
      ref_source_select_out      <= ctrl[`VRC_BIT_SOURCE];
      ref_level_value_out        <= ctrl[`VRC_LEVEL_MSB:`VRC_LEVEL_LSB];
      analog_out_pin_connect_out <= ctrl[`VRC_BIT_PIN_OE] & dir_stable;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_pin_gate_both: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    analog_out_pin_connect_out == ($past(ctrl[`VRC_BIT_PIN_OE]) && $past(dir_stable)))
    else $error("Pin connect does not follow enable and direction");

  a_write_stores: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    access_done && pwrite_in && is_ctrl(paddr_in) && pstrb_in[0]
    |=> ctrl == $past(pwdata_in[7:0]))
    else $error("Control write not stored");

  a_ctrl_held: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !(access_done && pwrite_in) |=> $stable(ctrl))
    else $error("Control register changed without a write");

  a_power_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ref_power_enable_out == $past(ctrl[`VRC_BIT_POWER]))
    else $error("Power enable output mismatch");

  a_pin_oe_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ref_pin_output_enable_out == $past(ctrl[`VRC_BIT_PIN_OE]))
    else $error("Pin output enable mismatch");

  a_range_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ref_range_select_out == $past(ctrl[`VRC_BIT_RANGE]))
    else $error("Range select mismatch");

  a_level_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ref_level_value_out == $past(ctrl[3:0]))
    else $error("Level value mismatch");

  a_source_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ref_source_select_out == $past(ctrl[`VRC_BIT_SOURCE]))
    else $error("Source select mismatch");

  a_read_returns: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == VRC_IDLE && psel_in && !penable_in && !pwrite_in && is_ctrl(paddr_in)
    |=> pready_out && prdata_out == {24'h00_0000, $past(ctrl)})
    else $error("Control read returned wrong data");

  a_ready_one_wait: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == VRC_IDLE && psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("Ready not a single cycle after setup");

  c_write_ctrl: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    access_done && pwrite_in && is_ctrl(paddr_in));
  c_pin_connect: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(analog_out_pin_connect_out));
  c_bad_addr: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    pready_out && pslverr_out);
endmodule

// file: vrc_defs.svh
// Register offsets, field positions and reset values for the voltage reference control.
`ifndef VRC_DEFS_SVH
`define VRC_DEFS_SVH
`define VRC_CTRL_ADDR       12'h000
`define VRC_STATUS_ADDR     12'h004
`define VRC_CTRL_RESET      8'h00
`define VRC_BIT_POWER       7
`define VRC_BIT_PIN_OE      6
`define VRC_BIT_RANGE       5
`define VRC_BIT_SOURCE      4
`define VRC_LEVEL_MSB       3
`define VRC_LEVEL_LSB       0
`define VRC_PIN_DIR_BIT     5
`define VRC_SYNC_STAGES     3
`endif

// file: vrc_pkg.sv
// Types shared by the voltage reference control block.
package vrc_pkg;
  typedef logic [7:0] vrc_reg_t;
  typedef logic [3:0] vrc_level_t;
  typedef enum logic [1:0] {
    VRC_IDLE   = 2'b01,
    VRC_ACCESS = 2'b10
  } vrc_state_e;
endpackage
